/* File: bench/bus_model.sv */
`timescale 1ns/10ps
module bus_model (
  input  wire logic       clk,
  input  wire logic       cs_high,
  output logic      [7:0] ch
);
  logic act = 1'b0;
  logic sck = 1'b0;
  logic sd = 1'b0;
  logic isck = 1'b0;
  logic ws = 1'b0;
  logic isd = 1'b0;
  assign ch = {2'h0, isd, ws, isck, sd, sck, act ~^ cs_high};
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // data stands two cycles around both clock edges, so either latch edge works
  task automatic spi_send(input logic [23:0] v, input int n);
    act <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      sd <= v[i];
      tick(2);
      sck <= 1'b1;
      tick(4);
      sck <= 1'b0;
      tick(2);
    end
    tick(2);
    act <= 1'b0;
    // released line must not keep its last value
    sd <= ~sd;
    tick(8);
  endtask
  // ws flips with the last bit of each word, as the word closes
  task automatic i2s_frame(input logic [15:0] l, input logic [15:0] r, input logic last);
    logic [31:0] w;
    w = {l, r};
    for (int i = 31; i >= 0; i--) begin
      isd <= w[i];
      ws <= (i >= 16) ? (i == 16) : (i != 0);
      tick(2);
      isck <= 1'b1;
      tick(4);
      isck <= 1'b0;
      tick(2);
    end
    // only the closing frame lets the line go, so frames never drive it twice
    if (last) isd <= ~isd;
  endtask
endmodule

/* File: bench/proto_trigger_properties.sv */
`timescale 1ns/10ps
module proto_trigger_properties
  import trig_pkg::*;
(
  input wire logic                          REF_CLK,
  input wire logic                          SRST,
  input wire logic [trig_pkg::NCH-1:0]      CH_IN,
  input wire logic                          PROTO_SPI,
  input wire logic [trig_pkg::CHSEL_W-1:0]  I2S_SCK_SEL,
  input wire logic [trig_pkg::BITS_W-1:0]   I2S_BITS,
  input trig_pkg::method_type               I2S_METHOD,
  input wire logic [trig_pkg::CHSEL_W-1:0]  SPI_SCK_SEL,
  input wire logic                          SPI_FALL_EDGE,
  input wire logic [trig_pkg::SPI_LEN_W-1:0] SPI_WLEN,
  input wire logic                          TRIG,
  input wire logic [trig_pkg::SAMP_W-1:0]   I2S_SAMPLE,
  input wire logic                          TIMING_ERR,
  input wire logic [trig_pkg::SPI_WMAX-1:0] SPI_WORD,
  input wire logic [1:0]                    SPI_HIT_IDX
);
  logic [7:0] i2s_hist_r = 8'h00;
  logic [7:0] spi_hist_r = 8'h00;
  logic       i2s_prev_r = 1'b0;
  logic       spi_prev_r = 1'b0;
  logic       i2s_now;
  logic       spi_now;
  assign i2s_now = CH_IN[I2S_SCK_SEL];
  assign spi_now = CH_IN[SPI_SCK_SEL];
  // pin edges kept for eight cycles so latencies can be tested as windows
  always_ff @(posedge REF_CLK) begin
    i2s_prev_r <= i2s_now;
    spi_prev_r <= spi_now;
    i2s_hist_r <= {i2s_hist_r[6:0], i2s_now & ~i2s_prev_r};
    spi_hist_r <= {spi_hist_r[6:0], (spi_now ^ spi_prev_r) & (spi_now ^ SPI_FALL_EDGE)};
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  property p_spi_pulse;
    PROTO_SPI && TRIG |=> !TRIG;
  endproperty
  a_spi_pulse: assert property (p_spi_pulse) else $error("spi trigger too long");
  property p_spi_hold;
    PROTO_SPI && $past(PROTO_SPI) && !$past(SRST) && !TRIG |->
      $stable(SPI_WORD) && $stable(SPI_HIT_IDX);
  endproperty
  a_spi_hold: assert property (p_spi_hold) else $error("spi result moved");
  property p_spi_width;
    PROTO_SPI && TRIG && SPI_WLEN == 5'h08 |-> SPI_WORD[23:8] == 16'h0000;
  endproperty
  a_spi_width: assert property (p_spi_width) else $error("spi word too wide");
  property p_spi_lat;
    PROTO_SPI && TRIG |-> |spi_hist_r[7:4];
  endproperty
  a_spi_lat: assert property (p_spi_lat) else $error("spi trigger off edge");
  property p_i2s_lat;
    !PROTO_SPI && I2S_METHOD != M_TIMING && TRIG |-> |i2s_hist_r[6:3];
  endproperty
  a_i2s_lat: assert property (p_i2s_lat) else $error("i2s trigger off edge");
  property p_samp_lat;
    $changed(I2S_SAMPLE) && !$past(SRST) |-> |i2s_hist_r[5:2];
  endproperty
  a_samp_lat: assert property (p_samp_lat) else $error("sample off edge");
  property p_sext;
    I2S_BITS == 6'h10 |-> I2S_SAMPLE[31:16] == {16{I2S_SAMPLE[15]}};
  endproperty
  a_sext: assert property (p_sext) else $error("sample not sign extended");
  property p_tv_trig;
    !PROTO_SPI && I2S_METHOD == M_TIMING |-> TRIG == TIMING_ERR;
  endproperty
  a_tv_trig: assert property (p_tv_trig) else $error("timing trigger mismatch");
endmodule

/* File: bench/proto_trigger_tb_top.sv */
`timescale 1ns/10ps
module proto_trigger_tb_top;
  import trig_pkg::*;
  logic                  REF_CLK = 1'b0;
  logic                  SRST = 1'b1;
  logic                  PROTO_SPI = 1'b0;
  logic                  SPI_CS_HIGH = 1'b0;
  logic                  SPI_FALL_EDGE = 1'b0;
  logic                  SPI_LSB_FIRST = 1'b0;
  logic [NCH-1:0]        CH_IN;
  logic [CHSEL_W-1:0]    SPI_CS_SEL = 3'h0, SPI_SCK_SEL = 3'h1, SPI_SD_SEL = 3'h2;
  logic [CHSEL_W-1:0]    I2S_SCK_SEL = 3'h3, I2S_WS_SEL = 3'h4, I2S_SD_SEL = 3'h5;
  logic [BITS_W-1:0]     I2S_BITS = 6'h10;
  chan_type              I2S_CHAN = SEL_BOTH;
  method_type            I2S_METHOD = M_MATCH;
  cmp_type               I2S_CMP = C_EQ;
  logic [SAMP_W-1:0]     PAT_A = 32'h0, PAT_B = 32'h0;
  logic [DUR_W-1:0]      DUR_FRAMES = 16'h0001;
  preset_type            TV_PRESET = TV_CUSTOM;
  logic [TCNT_W-1:0]     CUST_PER_MIN = 16'h0004, CUST_PER_MAX = 16'hFFFF;
  logic [TCNT_W-1:0]     CUST_HI_MIN = 16'h0002, CUST_LO_MIN = 16'h0002;
  logic [TCNT_W-1:0]     CUST_SETUP = 16'h0001, CUST_HOLD = 16'h0001;
  logic [SPI_LEN_W-1:0]  SPI_WLEN = 5'h08;
  logic [511:0]          SPI_PAT = '0;
  logic [19:0]           SPI_PAT_LEN = 20'h0;
  logic [PASS_W-1:0]     SPI_PASS = 16'h0;
  logic                  TRIG, I2S_SAMPLE_RIGHT, TIMING_ERR;
  logic [SAMP_W-1:0]     I2S_SAMPLE;
  logic [SPI_WMAX-1:0]   SPI_WORD;
  logic [1:0]            SPI_HIT_IDX;
  int                    n_fail = 0, total_checks = 0, trig_cnt = 0, cyc = 0;
  always #12.5 REF_CLK = ~REF_CLK;
  proto_trigger u_proto_trigger (
    .REF_CLK, .SRST, .CH_IN, .PROTO_SPI, .I2S_SCK_SEL, .I2S_WS_SEL, .I2S_SD_SEL,
    .I2S_BITS, .I2S_CHAN, .I2S_METHOD, .I2S_CMP, .PAT_A, .PAT_B, .DUR_FRAMES,
    .TV_PRESET, .CUST_PER_MIN, .CUST_PER_MAX, .CUST_HI_MIN, .CUST_LO_MIN, .CUST_SETUP,
    .CUST_HOLD, .SPI_CS_SEL, .SPI_SCK_SEL, .SPI_SD_SEL, .SPI_CS_HIGH, .SPI_FALL_EDGE,
    .SPI_WLEN, .SPI_LSB_FIRST, .SPI_PAT, .SPI_PAT_LEN, .SPI_PASS, .TRIG, .I2S_SAMPLE,
    .I2S_SAMPLE_RIGHT, .TIMING_ERR, .SPI_WORD, .SPI_HIT_IDX
  );
  bus_model u_bus_model (.clk(REF_CLK), .cs_high(SPI_CS_HIGH), .ch(CH_IN));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge REF_CLK) begin
    cyc++;
    if (TRIG === 1'b1) trig_cnt++;
    if (cyc == 12000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse_reset;
    SRST <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    SRST <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    trig_cnt = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_spi_pass;
    PROTO_SPI <= 1'b1;
    SPI_PAT[7:0] <= 8'hA5;
    SPI_PAT_LEN <= 20'h00001;
    SPI_PASS <= 16'h0001;
    pulse_reset();
    u_bus_model.spi_send(24'h00A5A5, 16);
    check("spi trig count", 1, trig_cnt);
    check("spi word", 24'h0000A5, SPI_WORD);
    check("spi index", 0, SPI_HIT_IDX);
    $display("test spi pass done");
  endtask
  // lsb first, falling edge, high select; a torn word precedes the frame
  task automatic t_spi_lsb;
    SPI_CS_HIGH <= 1'b1;
    SPI_FALL_EDGE <= 1'b1;
    SPI_LSB_FIRST <= 1'b1;
    SPI_PAT <= {120'h0, 8'h3A, 120'h0, 8'h12, 112'h0, 16'h123A, 128'h0};
    SPI_PAT_LEN <= 20'h08440;
    pulse_reset();
    u_bus_model.spi_send(24'h00001F, 5);
    u_bus_model.spi_send(24'h005C48, 16);
    check("spi trig count", 1, trig_cnt);
    check("spi word", 24'h000012, SPI_WORD);
    check("spi index", 1, SPI_HIT_IDX);
    $display("test spi lsb done");
  endtask
  task automatic t_i2s(input method_type m, input cmp_type c, input chan_type ch,
                       input logic [15:0] a, input logic [15:0] b, input logic [15:0] l0,
                       input logic [15:0] r0, input logic [15:0] l1, input logic [15:0] r1,
                       input int exp);
    PROTO_SPI <= 1'b0;
    I2S_METHOD <= m;
    I2S_CMP <= c;
    I2S_CHAN <= ch;
    PAT_A <= {{16{a[15]}}, a};
    PAT_B <= {{16{b[15]}}, b};
    DUR_FRAMES <= (c == C_EQ) ? 16'h0002 : 16'h0001;
    pulse_reset();
    u_bus_model.i2s_frame(l0, r0, 1'b0);
    u_bus_model.i2s_frame(l1, r1, 1'b1);
    repeat (12) @(posedge REF_CLK);
    if (exp < 0) check("timing trig", 1, trig_cnt > 0);
    else check("trig count", exp, trig_cnt);
    check("sample", {{16{r1[15]}}, r1}, I2S_SAMPLE);
    check("right", 1, I2S_SAMPLE_RIGHT);
    $display("test i2s %s done", m.name());
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge REF_CLK);
    SRST <= 1'b0;
    @(posedge REF_CLK);
    t_spi_pass();
    t_spi_lsb();
    t_i2s(M_MATCH, C_EQ, SEL_RIGHT, 16'h1234, 16'h0, 16'h1234, 16'h1234, 16'h1234,
          16'h1234, 1);
    t_i2s(M_MATCH, C_NE, SEL_LEFT, 16'h5, 16'h0, 16'h5, 16'h7, 16'h6, 16'h8, 1);
    t_i2s(M_MATCH, C_LT, SEL_LEFT, 16'h0, 16'h0, 16'hFFFF, 16'h0, 16'h1, 16'h0, 1);
    t_i2s(M_MATCH, C_GT, SEL_LEFT, 16'h10, 16'h0, 16'h10, 16'h0, 16'h11, 16'h0, 1);
    t_i2s(M_MATCH, C_IN, SEL_LEFT, 16'h10, 16'h20, 16'h15, 16'h0, 16'h25, 16'h0, 1);
    t_i2s(M_MATCH, C_OUT, SEL_LEFT, 16'h10, 16'h20, 16'h15, 16'h0, 16'h25, 16'h0, 1);
    t_i2s(M_RISE, C_NE, SEL_LEFT, 16'h10, 16'h20, 16'h5, 16'h0, 16'h30, 16'h0, 1);
    t_i2s(M_FALL, C_NE, SEL_LEFT, 16'h10, 16'h20, 16'h30, 16'h0, 16'h5, 16'h0, 1);
    t_i2s(M_GLITCH, C_NE, SEL_LEFT, 16'h40, 16'h0, 16'h10, 16'h0, 16'h60, 16'h0, 1);
    t_i2s(M_MUTE, C_NE, SEL_BOTH, 16'h100, 16'h0, 16'hFF, 16'hFF00, 16'h200, 16'hFF01,
          2);
    t_i2s(M_CLIP, C_NE, SEL_BOTH, 16'h100, 16'h0, 16'hFF, 16'hFF00, 16'h200, 16'hFF01,
          2);
    t_i2s(M_TIMING, C_NE, SEL_BOTH, 16'h0, 16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 0);
    CUST_PER_MIN <= 16'h000A;
    t_i2s(M_TIMING, C_NE, SEL_BOTH, 16'h0, 16'h0, 16'h1, 16'h2, 16'h3, 16'h4, -1);
    TV_PRESET <= TV_MASTER;
    t_i2s(M_TIMING, C_NE, SEL_BOTH, 16'h0, 16'h0, 16'h1, 16'h2, 16'h3, 16'h4, -1);
    TV_PRESET <= TV_SLAVE;
    t_i2s(M_TIMING, C_NE, SEL_BOTH, 16'h0, 16'h0, 16'h1, 16'h2, 16'h3, 16'h4, -1);
    finish_test();
  end
endmodule
bind proto_trigger proto_trigger_properties u_proto_trigger_properties (
  .REF_CLK, .SRST, .CH_IN, .PROTO_SPI, .I2S_SCK_SEL, .I2S_BITS, .I2S_METHOD, .SPI_SCK_SEL,
  .SPI_FALL_EDGE, .SPI_WLEN, .TRIG, .I2S_SAMPLE, .TIMING_ERR, .SPI_WORD, .SPI_HIT_IDX
);

/* File: pkg/trig_pkg.sv */
package trig_pkg;
  localparam int NCH       = 8;
  localparam int CHSEL_W   = 3;
  localparam int SAMP_W    = 32;
  localparam int BITS_W    = 6;
  localparam int DUR_W     = 16;
  localparam int TCNT_W    = 16;
  localparam int PASS_W    = 16;
  localparam int SPI_WMAX  = 24;
  localparam int SPI_WMIN  = 4;
  localparam int SPI_LEN_W = 5;
  localparam int SPI_NPAT  = 4;
  localparam int SPI_NENT  = 16;
  localparam int SPI_ENT_W = 8;
  localparam int SPI_POS_W = 5;
  localparam int CLK_NS    = 25;
  // timing presets in ns
  localparam int MST_PER_MIN_NS = 360;
  localparam int MST_PER_MAX_NS = 440;
  localparam int MST_HI_MIN_NS  = 160;
  localparam int MST_LO_MIN_NS  = 160;
  localparam int MST_SU_NS      = 0;
  localparam int MST_HD_NS      = 100;
  localparam int SLV_PER_MIN_NS = 300;
  localparam int SLV_PER_MAX_NS = 600;
  localparam int SLV_HI_MIN_NS  = 120;
  localparam int SLV_LO_MIN_NS  = 120;
  localparam int SLV_SU_NS      = 25;
  localparam int SLV_HD_NS      = 50;
  function automatic logic [TCNT_W-1:0] cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) c = 1;
    return TCNT_W'(c);
  endfunction
  function automatic logic [TCNT_W-1:0] cyc_max(input int ns);
    int c;
    c = ns / CLK_NS;
    if (c < 1) c = 1;
    return TCNT_W'(c);
  endfunction
  typedef enum logic [2:0] {M_MATCH, M_RISE, M_FALL, M_GLITCH, M_MUTE, M_CLIP,
                            M_TIMING} method_type;
  typedef enum logic [2:0] {C_EQ, C_NE, C_LT, C_GT, C_IN, C_OUT} cmp_type;
  typedef enum logic [1:0] {SEL_BOTH, SEL_LEFT, SEL_RIGHT} chan_type;
  typedef enum logic [1:0] {TV_MASTER, TV_SLAVE, TV_CUSTOM} preset_type;
endpackage

/* File: rtl/pin_sampler.sv */
`timescale 1ns/10ps
module pin_sampler #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } st_type;
  st_type s_r;
  st_type s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // edges look only at the second and third stage
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign lvl[g]  = s_r.s2[g];
      assign rise[g] = s_r.s2[g] & ~s_r.s3[g];
      assign fall[g] = ~s_r.s2[g] & s_r.s3[g];
    end
  endgenerate
endmodule

/* File: rtl/proto_trigger.sv */
`timescale 1ns/10ps
module proto_trigger
  import trig_pkg::*;
(
  input  wire logic                                         REF_CLK,
  input  wire logic                                         SRST,
  input  wire logic [trig_pkg::NCH-1:0]                     CH_IN,
  input  wire logic                                         PROTO_SPI,
  input  wire logic [trig_pkg::CHSEL_W-1:0]                 I2S_SCK_SEL,
  input  wire logic [trig_pkg::CHSEL_W-1:0]                 I2S_WS_SEL,
  input  wire logic [trig_pkg::CHSEL_W-1:0]                 I2S_SD_SEL,
  input  wire logic [trig_pkg::BITS_W-1:0]                  I2S_BITS,
  input  trig_pkg::chan_type                                I2S_CHAN,
  input  trig_pkg::method_type                              I2S_METHOD,
  input  trig_pkg::cmp_type                                 I2S_CMP,
  input  wire logic [trig_pkg::SAMP_W-1:0]                  PAT_A,
  input  wire logic [trig_pkg::SAMP_W-1:0]                  PAT_B,
  input  wire logic [trig_pkg::DUR_W-1:0]                   DUR_FRAMES,
  input  trig_pkg::preset_type                              TV_PRESET,
  input  wire logic [trig_pkg::TCNT_W-1:0]                  CUST_PER_MIN,
  input  wire logic [trig_pkg::TCNT_W-1:0]                  CUST_PER_MAX,
  input  wire logic [trig_pkg::TCNT_W-1:0]                  CUST_HI_MIN,
  input  wire logic [trig_pkg::TCNT_W-1:0]                  CUST_LO_MIN,
  input  wire logic [trig_pkg::TCNT_W-1:0]                  CUST_SETUP,
  input  wire logic [trig_pkg::TCNT_W-1:0]                  CUST_HOLD,
  input  wire logic [trig_pkg::CHSEL_W-1:0]                 SPI_CS_SEL,
  input  wire logic [trig_pkg::CHSEL_W-1:0]                 SPI_SCK_SEL,
  input  wire logic [trig_pkg::CHSEL_W-1:0]                 SPI_SD_SEL,
  input  wire logic                                         SPI_CS_HIGH,
  input  wire logic                                         SPI_FALL_EDGE,
  input  wire logic [trig_pkg::SPI_LEN_W-1:0]               SPI_WLEN,
  input  wire logic                                         SPI_LSB_FIRST,
  input  wire logic [trig_pkg::SPI_NPAT*trig_pkg::SPI_NENT*trig_pkg::SPI_ENT_W-1:0] SPI_PAT,
  input  wire logic [trig_pkg::SPI_NPAT*trig_pkg::SPI_LEN_W-1:0] SPI_PAT_LEN,
  input  wire logic [trig_pkg::PASS_W-1:0]                  SPI_PASS,
  output logic                                              TRIG,
  output logic [trig_pkg::SAMP_W-1:0]                       I2S_SAMPLE,
  output logic                                              I2S_SAMPLE_RIGHT,
  output logic                                              TIMING_ERR,
  output logic [trig_pkg::SPI_WMAX-1:0]                     SPI_WORD,
  output logic [1:0]                                        SPI_HIT_IDX
);
  import trig_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and channel routing

  logic [NCH-1:0] lvl;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;

  pin_sampler #(
    .W    (NCH)
  ) u_sampler (
    .clk  (REF_CLK),
    .srst (SRST),
    .din  (CH_IN),
    .lvl  (lvl),
    .rise (rise),
    .fall (fall)
  );

  logic sck;
  logic sck_r;
  logic sck_f;
  logic ws;
  logic sd;
  logic sd_edge;

  always_comb begin
    sck     = lvl[I2S_SCK_SEL];
    sck_r   = rise[I2S_SCK_SEL];
    sck_f   = fall[I2S_SCK_SEL];
    ws      = lvl[I2S_WS_SEL];
    sd      = lvl[I2S_SD_SEL];
    sd_edge = rise[I2S_SD_SEL] | fall[I2S_SD_SEL];
  end

  ////////////////////////////////////////////////////////////////////////////
  // SPI side

  logic                spi_trig;
  logic [1:0]          spi_idx;
  logic [SPI_WMAX-1:0] spi_word;

  spi_matcher u_spi (
    .clk       (REF_CLK),
    .srst      (SRST),
    .cs        (lvl[SPI_CS_SEL]),
    .sck_rise  (rise[SPI_SCK_SEL]),
    .sck_fall  (fall[SPI_SCK_SEL]),
    .sd        (lvl[SPI_SD_SEL]),
    .cs_high   (SPI_CS_HIGH),
    .fall_edge (SPI_FALL_EDGE),
    .wlen      (SPI_WLEN),
    .lsb_first (SPI_LSB_FIRST),
    .pat       (SPI_PAT),
    .pat_len   (SPI_PAT_LEN),
    .pass      (SPI_PASS),
    .trig      (spi_trig),
    .hit_idx   (spi_idx),
    .word      (spi_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // timing limits

  logic [TCNT_W-1:0] lim_per_min;
  logic [TCNT_W-1:0] lim_per_max;
  logic [TCNT_W-1:0] lim_hi;
  logic [TCNT_W-1:0] lim_lo;
  logic [TCNT_W-1:0] lim_su;
  logic [TCNT_W-1:0] lim_hd;

  always_comb begin
    case (TV_PRESET)
      TV_MASTER: begin
        lim_per_min = cyc_min(MST_PER_MIN_NS);
        lim_per_max = cyc_max(MST_PER_MAX_NS);
        lim_hi      = cyc_min(MST_HI_MIN_NS);
        lim_lo      = cyc_min(MST_LO_MIN_NS);
        lim_su      = cyc_min(MST_SU_NS);
        lim_hd      = cyc_min(MST_HD_NS);
      end
      TV_SLAVE: begin
        lim_per_min = cyc_min(SLV_PER_MIN_NS);
        lim_per_max = cyc_max(SLV_PER_MAX_NS);
        lim_hi      = cyc_min(SLV_HI_MIN_NS);
        lim_lo      = cyc_min(SLV_LO_MIN_NS);
        lim_su      = cyc_min(SLV_SU_NS);
        lim_hd      = cyc_min(SLV_HD_NS);
      end
      default: begin
        lim_per_min = CUST_PER_MIN;
        lim_per_max = CUST_PER_MAX;
        lim_hi      = CUST_HI_MIN;
        lim_lo      = CUST_LO_MIN;
        lim_su      = CUST_SETUP;
        lim_hd      = CUST_HOLD;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2S state

  typedef struct packed {
    logic [SAMP_W-1:0] sh;
    logic [BITS_W-1:0] bcnt;
    logic              ws_last;
    logic [SAMP_W-1:0] samp;
    logic              samp_right;
    logic              samp_vld;
    logic [SAMP_W-1:0] prev_l;
    logic [SAMP_W-1:0] prev_r;
    logic [DUR_W-1:0]  dur;
    logic [TCNT_W-1:0] per_cnt;
    logic [TCNT_W-1:0] ph_cnt;
    logic [TCNT_W-1:0] sd_age;
    logic              per_vld;
    logic              ph_vld;
    logic              sd_vld;
    logic              tv;
    logic              trig;
    logic [SPI_WMAX-1:0] spi_word;
    logic [1:0]        spi_idx;
  } st_type;
  st_type s_r;
  st_type s_nxt;

  function automatic logic [TCNT_W-1:0] sat_inc(input logic [TCNT_W-1:0] v);
    return (&v) ? v : v + 1'b1;
  endfunction

  logic [SAMP_W-1:0]   sh_in;
  logic [SAMP_W-1:0]   new_samp;
  logic [5:0]          ext;
  logic signed [32:0]  x;
  logic signed [32:0]  p;
  logic signed [32:0]  a;
  logic signed [32:0]  b;
  logic signed [32:0]  d;
  logic                cmp_ok;
  logic                cond;
  logic                use_dur;
  logic                chan_ok;
  logic                fire;
  logic [BITS_W-1:0]   nbits;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.samp_vld = 1'b0;
    s_nxt.tv       = 1'b0;
    s_nxt.trig     = 1'b0;
    // 0 is meaningless, so treat it as one bit; above 32 clamps
    if (I2S_BITS == '0) nbits = BITS_W'(1);
    else if (I2S_BITS > BITS_W'(SAMP_W)) nbits = BITS_W'(SAMP_W);
    else nbits = I2S_BITS;
    ext      = 6'(SAMP_W - 32'(nbits));
    sh_in    = (s_r.bcnt < nbits) ? {s_r.sh[SAMP_W-2:0], sd} : s_r.sh;
    new_samp = SAMP_W'($signed(sh_in << ext) >>> ext);

    // word assembly: the bit on the word-select change closes the old word
    if (sck_r) begin
      if (ws != s_r.ws_last) begin
        s_nxt.samp       = new_samp;
        s_nxt.samp_right = s_r.ws_last;
        s_nxt.samp_vld   = 1'b1;
        s_nxt.sh         = '0;
        s_nxt.bcnt       = '0;
        s_nxt.ws_last    = ws;
      end else begin
        s_nxt.sh   = sh_in;
        s_nxt.bcnt = (s_r.bcnt < nbits) ? s_r.bcnt + 1'b1 : s_r.bcnt;
      end
    end

    // sample evaluation, one cycle after the word closes
    x = 33'($signed(s_r.samp));
    p = 33'($signed(s_r.samp_right ? s_r.prev_r : s_r.prev_l));
    a = 33'($signed(PAT_A));
    b = 33'($signed(PAT_B));
    d = (x > p) ? x - p : p - x;
    case (I2S_CMP)
      C_EQ:    cmp_ok = x == a;
      C_NE:    cmp_ok = x != a;
      C_LT:    cmp_ok = x < a;
      C_GT:    cmp_ok = x > a;
      C_IN:    cmp_ok = (x >= a) && (x <= b);
      C_OUT:   cmp_ok = (x < a) || (x > b);
      default: cmp_ok = 1'b0;
    endcase
    use_dur = 1'b0;
    case (I2S_METHOD)
      M_MATCH: begin
        cond    = cmp_ok;
        use_dur = 1'b1;
      end
      M_RISE:   cond = (p < a) && (x > b);
      M_FALL:   cond = (p > b) && (x < a);
      M_GLITCH: cond = d > a;
      M_MUTE: begin
        cond    = (x > -a) && (x < a);
        use_dur = 1'b1;
      end
      M_CLIP: begin
        cond    = (x <= -a) || (x >= a);
        use_dur = 1'b1;
      end
      default: cond = 1'b0;
    endcase
    case (I2S_CHAN)
      SEL_LEFT:  chan_ok = !s_r.samp_right;
      SEL_RIGHT: chan_ok = s_r.samp_right;
      default:   chan_ok = 1'b1;
    endcase
    fire = 1'b0;
    if (s_r.samp_vld && chan_ok) begin
      if (s_r.samp_right) s_nxt.prev_r = s_r.samp;
      else s_nxt.prev_l = s_r.samp;
      if (cond) begin
        s_nxt.dur = (&s_r.dur) ? s_r.dur : s_r.dur + 1'b1;
        // duration 0 behaves as 1
        fire = !use_dur || (s_r.dur + 1'b1 >= DUR_FRAMES);
      end else begin
        s_nxt.dur = '0;
      end
    end

    // bit clock timing
    s_nxt.per_cnt = sat_inc(s_r.per_cnt);
    s_nxt.ph_cnt  = sat_inc(s_r.ph_cnt);
    s_nxt.sd_age  = sat_inc(s_r.sd_age);
    if (sck_r) begin
      if (s_r.per_vld && (s_r.per_cnt < lim_per_min || s_r.per_cnt > lim_per_max))
        s_nxt.tv = 1'b1;
      if (s_r.ph_vld && s_r.ph_cnt < lim_lo) s_nxt.tv = 1'b1;
      if (s_r.sd_vld && s_r.sd_age < lim_su) s_nxt.tv = 1'b1;
      s_nxt.per_cnt = TCNT_W'(1);
      s_nxt.ph_cnt  = TCNT_W'(1);
      s_nxt.per_vld = 1'b1;
      s_nxt.ph_vld  = 1'b1;
    end
    if (sck_f) begin
      if (s_r.ph_vld && s_r.ph_cnt < lim_hi) s_nxt.tv = 1'b1;
      s_nxt.ph_cnt = TCNT_W'(1);
      s_nxt.ph_vld = 1'b1;
    end
    if (sd_edge) begin
      // hold counts from the last rising bit clock edge
      if (s_r.per_vld && sck && s_r.per_cnt < lim_hd) s_nxt.tv = 1'b1;
      s_nxt.sd_age = TCNT_W'(1);
      s_nxt.sd_vld = 1'b1;
    end
    if (I2S_METHOD == M_TIMING) fire = s_nxt.tv;

    s_nxt.trig = PROTO_SPI ? spi_trig : fire;
    if (spi_trig) begin
      s_nxt.spi_word = spi_word;
      s_nxt.spi_idx  = spi_idx;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign TRIG             = s_r.trig;
  assign I2S_SAMPLE       = s_r.samp;
  assign I2S_SAMPLE_RIGHT = s_r.samp_right;
  assign TIMING_ERR       = s_r.tv;
  assign SPI_WORD         = s_r.spi_word;
  assign SPI_HIT_IDX      = s_r.spi_idx;
endmodule

/* File: rtl/spi_matcher.sv */
`timescale 1ns/10ps
module spi_matcher
  import trig_pkg::*;
(
  input  wire logic                                    clk,
  input  wire logic                                    srst,
  input  wire logic                                    cs,
  input  wire logic                                    sck_rise,
  input  wire logic                                    sck_fall,
  input  wire logic                                    sd,
  input  wire logic                                    cs_high,
  input  wire logic                                    fall_edge,
  input  wire logic [SPI_LEN_W-1:0]                    wlen,
  input  wire logic                                    lsb_first,
  input  wire logic [SPI_NPAT*SPI_NENT*SPI_ENT_W-1:0] pat,
  input  wire logic [SPI_NPAT*SPI_LEN_W-1:0]          pat_len,
  input  wire logic [PASS_W-1:0]                       pass,
  output logic                                         trig,
  output logic [1:0]                                   hit_idx,
  output logic [SPI_WMAX-1:0]                          word
);
  typedef struct packed {
    logic [SPI_WMAX-1:0]                 sh;
    logic [SPI_LEN_W-1:0]                bcnt;
    logic [SPI_WMAX-1:0]                 word;
    logic                                wvld;
    logic [SPI_NPAT-1:0][SPI_POS_W-1:0]  pos;
    logic [PASS_W-1:0]                   pcnt;
    logic                                trig;
    logic [1:0]                          idx;
  } st_type;
  st_type s_r;
  st_type s_nxt;

  logic [SPI_NPAT-1:0]                 hit;
  logic [SPI_NPAT-1:0][SPI_POS_W-1:0]  npos;

  genvar g;
  generate
    for (g = 0; g < SPI_NPAT; g++) begin : g_pat
      logic [SPI_ENT_W-1:0] ent;
      logic [SPI_ENT_W-1:0] ent0;
      logic [SPI_LEN_W-1:0] len;
      logic                 eq;
      assign ent  = pat[(g*SPI_NENT + 32'(s_r.pos[g][3:0]))*SPI_ENT_W +: SPI_ENT_W];
      assign ent0 = pat[g*SPI_NENT*SPI_ENT_W +: SPI_ENT_W];
      assign len  = pat_len[g*SPI_LEN_W +: SPI_LEN_W];
      assign eq   = s_r.word == {{(SPI_WMAX-SPI_ENT_W){1'b0}}, ent};
      // a miss may still start the sequence again on this word
      // each pattern keeps its own place; a hit elsewhere leaves it running
      assign npos[g] = hit[g] ? '0 :
                       eq ? s_r.pos[g] + 1'b1 :
                       (s_r.word == {{(SPI_WMAX-SPI_ENT_W){1'b0}}, ent0}) ?
                       SPI_POS_W'(1) : '0;
      assign hit[g]  = (len != '0) && eq && (s_r.pos[g] + 1'b1 == len);
    end
  endgenerate

  logic                 cs_act;
  logic                 edge_p;
  logic [SPI_LEN_W-1:0] wl;
  logic [SPI_WMAX-1:0]  sh_in;

  always_comb begin
    cs_act = cs_high ? cs : ~cs;
    edge_p = fall_edge ? sck_fall : sck_rise;
    if (wlen < SPI_LEN_W'(SPI_WMIN)) wl = SPI_LEN_W'(SPI_WMIN);
    else if (wlen > SPI_LEN_W'(SPI_WMAX)) wl = SPI_LEN_W'(SPI_WMAX);
    else wl = wlen;
    if (lsb_first) sh_in = s_r.sh | (SPI_WMAX'(sd) << s_r.bcnt);
    else sh_in = {s_r.sh[SPI_WMAX-2:0], sd};
    s_nxt      = s_r;
    s_nxt.wvld = 1'b0;
    s_nxt.trig = 1'b0;
    if (!cs_act) begin
      s_nxt.sh   = '0;
      s_nxt.bcnt = '0;
    end else if (edge_p) begin
      if (s_r.bcnt + 1'b1 == wl) begin
        s_nxt.word = sh_in;
        s_nxt.wvld = 1'b1;
        s_nxt.sh   = '0;
        s_nxt.bcnt = '0;
      end else begin
        s_nxt.sh   = sh_in;
        s_nxt.bcnt = s_r.bcnt + 1'b1;
      end
    end
    if (s_r.wvld) begin
      s_nxt.pos = npos;
      if (|hit) begin
        if (s_r.pcnt >= pass) begin
          s_nxt.trig = 1'b1;
          s_nxt.pcnt = '0;
          s_nxt.idx  = hit[0] ? 2'h0 : hit[1] ? 2'h1 : hit[2] ? 2'h2 : 2'h3;
        end else begin
          s_nxt.pcnt = s_r.pcnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign trig    = s_r.trig;
  assign hit_idx = s_r.idx;
  assign word    = s_r.word;
endmodule
